// >>> rtl/sps_pkg.sv
// Package for the state playback sequencer: commands, modes, timing constants.
// Assumes a single 200 MHz clock domain and a register port driven by host software.
package sps_pkg;

	// Clock period in picoseconds.
	localparam int unsigned CLK_PERIOD_PS = 5000;

	// Register byte offsets.
	localparam logic [7:0] REG_COMMAND   = 8'h00;
	localparam logic [7:0] REG_CONFIG    = 8'h04;
	localparam logic [7:0] REG_LOOPS     = 8'h08;
	localparam logic [7:0] REG_NUM_STATE = 8'h0C;
	localparam logic [7:0] REG_STATUS    = 8'h10;
	localparam logic [7:0] REG_PROGRESS  = 8'h14;
	localparam logic [7:0] REG_LOOPCNT   = 8'h18;
	localparam logic [7:0] REG_TABLE     = 8'h40;

	// Command register bit positions; a write with the bit set issues the command.
	localparam int unsigned CMD_ARM    = 0;
	localparam int unsigned CMD_RUN    = 1;
	localparam int unsigned CMD_PAUSE  = 2;
	localparam int unsigned CMD_RESUME = 3;
	localparam int unsigned CMD_STOP   = 4;
	localparam int unsigned CMD_STEP   = 5;

	// Config field positions.
	localparam int unsigned CFG_PLAY_LSB = 0;
	localparam int unsigned CFG_TRIG_LSB = 2;

	// Reset values.
	localparam logic [1:0]  PLAY_RESET  = 2'h0;
	localparam logic [1:0]  TRIG_RESET  = 2'h0;
	localparam logic [15:0] LOOPS_RESET = 16'h0001;

	// Playback modes.
	typedef enum logic [1:0] {
		SPS_PLAY_ONCE  = 2'b00,
		SPS_PLAY_LOOPN = 2'b01,
		SPS_PLAY_CONT  = 2'b10
	} sps_play_t;

	// Trigger sources.
	typedef enum logic [1:0] {
		SPS_TRIG_INT  = 2'b00,
		SPS_TRIG_STEP = 2'b01,
		SPS_TRIG_EXT  = 2'b10
	} sps_trig_t;

	// Sequencer states.
	typedef enum logic [2:0] {
		SPS_ST_STATIC = 3'b000,
		SPS_ST_ARMED  = 3'b001,
		SPS_ST_RUN    = 3'b010,
		SPS_ST_PAUSE  = 3'b011
	} sps_state_t;

	// External trigger timing in microseconds.
	localparam int unsigned EXT_DELAY_MIN_US = 2900;
	localparam int unsigned EXT_DELAY_MAX_US = 4300;
	localparam int unsigned EXT_REARM_US     = 2400;
	// Monitor pulse high time in microseconds, 0.6 ms to 1.4 ms allowed.
	localparam int unsigned MON_PULSE_US     = 1000;

	// Cycle counts: a least time rounds up; microseconds become picoseconds first.
	localparam int unsigned EXT_DELAY_CYC = (EXT_DELAY_MIN_US * 1000 * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int unsigned EXT_REARM_CYC = (EXT_REARM_US * 1000 * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int unsigned MON_PULSE_CYC = (MON_PULSE_US * 1000 * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;

endpackage

// >>> rtl/sps_down_counter.sv
// Loadable down counter that signals when it reaches zero.
// Assumes the loader pulses load for one cycle; counts on every rising clock edge while hold is low.
`timescale 1ns/10ps
`default_nettype none
module sps_down_counter #(
	parameter int unsigned WIDTH = 20
) (
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	input  wire logic             hold,
	output logic                  busy,
	output logic                  done
);

	// Remaining count.
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic             next_done;

	// Next value: load wins, hold freezes, otherwise count down to zero.
	always_comb begin
		next_count = count;
		next_done  = 1'b0;
		if (load) begin
			next_count = load_value;
		end else if (!hold && count != '0) begin
			next_count = count - WIDTH'(1);
			next_done  = (count == WIDTH'(1));
		end
	end

	// Register stage.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			count <= '0;
			done  <= 1'b0;
		end else begin
			count <= next_count;
			done  <= next_done;
		end
	end

	// Counter is busy while nonzero.
	assign busy = (count != '0);

endmodule
`default_nettype wire

// >>> rtl/sps_sequencer.sv
// State playback sequencer: arms, runs, pauses and stops playback of a state list.
// Assumes a host on the plain register port and an asynchronous trigger pin.
//
// Notes on behaviour
// - Arm enters playback mode, loads first state.
// - Run starts timing first state immediately.
// - Every state change applied the same way.
// - Pause suspends; resume continues at same point.
// - Once mode stops after one pass.
// - Completion restores pre-arm static settings.
// - Loop-N mode repeats list N times.
// - Continuous mode loops until stop.
// - Stop ends playback, returns to static.
// - Internal trigger: state lasts programmed duration.
// - Each step command advances one state.
// - External trigger rising edge starts change.
// - Report states executed against total.
// - External change 2.9 to 4.3 ms later.
// - Accept new trigger after 2.4 ms.
// - One pending trigger; discard further ones.
// - Monitor pulse per change; low while armed.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module sps_sequencer #(
	parameter int unsigned STATE_W  = 4,
	parameter int unsigned DUR_W    = 24,
	parameter int unsigned EXT_DELAY_CYC = sps_pkg::EXT_DELAY_CYC,
	parameter int unsigned EXT_REARM_CYC = sps_pkg::EXT_REARM_CYC,
	parameter int unsigned MON_PULSE_CYC = sps_pkg::MON_PULSE_CYC
) (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        trig_in,
	output logic             state_mon,
	output logic             dyn_mode,
	output logic             state_apply,
	output logic [STATE_W-1:0] state_index
);

	localparam int unsigned DEPTH = 1 << STATE_W;

	// Settings held while static.
	logic [1:0]         play_mode;
	logic [1:0]         trig_mode;
	logic [15:0]        loops;
	logic [STATE_W:0]   num_states;
	// Per-state durations in clock cycles.
	logic [DUR_W-1:0]   dur_mem [DEPTH];
	// Sequencer state and progress.
	sps_pkg::sps_state_t st, next_st;
	logic [STATE_W-1:0] idx, next_idx;
	logic [15:0]        loop_cnt, next_loop_cnt;
	logic [STATE_W:0]   executed, next_executed;
	logic               pending, next_pending;
	logic [31:0]        rdata_q;
	// Trigger synchroniser and edge detect.
	logic               trig_s1, trig_s2, trig_s3;
	logic               trig_rise;

	// Command decode from a write to the command register.
	logic cmd_wr;
	logic c_arm, c_run, c_pause, c_resume, c_stop, c_step;
	assign cmd_wr   = reg_wr && reg_addr == sps_pkg::REG_COMMAND;
	assign c_arm    = cmd_wr && reg_wdata[sps_pkg::CMD_ARM];
	assign c_run    = cmd_wr && reg_wdata[sps_pkg::CMD_RUN];
	assign c_pause  = cmd_wr && reg_wdata[sps_pkg::CMD_PAUSE];
	assign c_resume = cmd_wr && reg_wdata[sps_pkg::CMD_RESUME];
	assign c_stop   = cmd_wr && reg_wdata[sps_pkg::CMD_STOP];
	assign c_step   = cmd_wr && reg_wdata[sps_pkg::CMD_STEP];

	// Timers: state duration, external delay, trigger rearm, monitor pulse.
	logic dur_load, dur_busy, dur_done;
	logic ext_load, ext_busy, ext_done;
	logic rearm_busy, mon_busy;
	logic paused;
	logic advance;
	assign paused = (st == sps_pkg::SPS_ST_PAUSE);
	// The duration and delay timers freeze from the pause edge itself, so no expiry is lost inside a pause.
	logic timer_hold;
	assign timer_hold = paused || (c_pause && st == sps_pkg::SPS_ST_RUN);

	sps_down_counter #(.WIDTH(DUR_W)) u_dur (
		.mclk       (mclk),
		.sys_rst    (sys_rst),
		.load       (dur_load),
		.load_value (dur_mem[next_idx]),
		.hold       (timer_hold),
		.busy       (dur_busy),
		.done       (dur_done)
	);

	sps_down_counter #(.WIDTH(20)) u_ext (
		.mclk       (mclk),
		.sys_rst    (sys_rst),
		.load       (ext_load),
		.load_value (20'(EXT_DELAY_CYC)),
		.hold       (timer_hold),
		.busy       (ext_busy),
		.done       (ext_done)
	);

	sps_down_counter #(.WIDTH(20)) u_rearm (
		.mclk       (mclk),
		.sys_rst    (sys_rst),
		.load       (trig_rise && st == sps_pkg::SPS_ST_RUN && !rearm_busy),
		.load_value (20'(EXT_REARM_CYC)),
		.hold       (1'b0),
		.busy       (rearm_busy),
		.done       ()
	);

	sps_down_counter #(.WIDTH(20)) u_mon (
		.mclk       (mclk),
		.sys_rst    (sys_rst),
		.load       (advance),
		.load_value (20'(MON_PULSE_CYC)),
		.hold       (1'b0),
		.busy       (mon_busy),
		.done       ()
	);

	// Trigger pin passes two flip-flops, then a third stage for edge detect.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_s3 <= 1'b0;
		end else begin
			trig_s1 <= trig_in;
			trig_s2 <= trig_s1;
			trig_s3 <= trig_s2;
		end
	end
	assign trig_rise = trig_s2 && !trig_s3;

	// Trigger acceptance: a rising edge outside the rearm window is accepted.
	logic ext_accept;
	assign ext_accept = trig_mode == sps_pkg::SPS_TRIG_EXT && st == sps_pkg::SPS_ST_RUN
		&& trig_rise && !rearm_busy;

	// Advance request from the selected trigger source.
	always_comb begin
		advance = 1'b0;
		unique case (trig_mode)
			sps_pkg::SPS_TRIG_INT:  advance = dur_done && st == sps_pkg::SPS_ST_RUN;
			sps_pkg::SPS_TRIG_STEP: advance = c_step && st == sps_pkg::SPS_ST_RUN;
			sps_pkg::SPS_TRIG_EXT:  advance = ext_done && st == sps_pkg::SPS_ST_RUN;
			default:                advance = 1'b0;
		endcase
	end

	// The delay timer starts on an accepted edge when idle, or from the pending slot.
	assign ext_load = (ext_accept && !ext_busy) || (ext_done && pending);
	// Duration restarts at run and at each change.
	assign dur_load = c_run && st == sps_pkg::SPS_ST_ARMED || advance;

	// Sequencer next-state logic.
	always_comb begin
		next_st       = st;
		next_idx      = idx;
		next_loop_cnt = loop_cnt;
		next_executed = executed;
		next_pending  = pending;
		unique case (st)
			sps_pkg::SPS_ST_STATIC: begin
				if (c_arm && num_states != '0) begin
					next_st       = sps_pkg::SPS_ST_ARMED;
					next_idx      = '0;
					next_loop_cnt = '0;
					next_executed = '0;
					next_pending  = 1'b0;
				end
			end
			sps_pkg::SPS_ST_ARMED: begin
				if (c_run) begin
					next_st = sps_pkg::SPS_ST_RUN;
				end
			end
			sps_pkg::SPS_ST_RUN: begin
				if (ext_done) begin
					// An edge in the cycle the slot empties refills it, so the set wins.
					next_pending = pending && ext_accept;
				end else if (ext_accept && ext_busy) begin
					next_pending = 1'b1;
				end
				if (advance) begin
					next_executed = executed + (STATE_W+1)'(1);
					if ({1'b0, idx} == num_states - (STATE_W+1)'(1)) begin
						next_idx      = '0;
						next_executed = '0;
						next_loop_cnt = loop_cnt + 16'h0001;
						unique case (play_mode)
							sps_pkg::SPS_PLAY_ONCE: next_st = sps_pkg::SPS_ST_STATIC;
							sps_pkg::SPS_PLAY_LOOPN: begin
								if (loop_cnt + 16'h0001 >= loops) begin
									next_st = sps_pkg::SPS_ST_STATIC;
								end
							end
							default: next_st = sps_pkg::SPS_ST_RUN;
						endcase
					end else begin
						next_idx = idx + STATE_W'(1);
					end
				end
				// A pause in the cycle of a change takes effect after that change.
				if (c_pause && next_st == sps_pkg::SPS_ST_RUN) begin
					next_st = sps_pkg::SPS_ST_PAUSE;
				end
			end
			sps_pkg::SPS_ST_PAUSE: begin
				if (c_resume) begin
					next_st = sps_pkg::SPS_ST_RUN;
				end
			end
			default: next_st = sps_pkg::SPS_ST_STATIC;
		endcase
		if (c_stop) begin
			next_st      = sps_pkg::SPS_ST_STATIC;
			next_pending = 1'b0;
		end
	end

	// Sequencer registers.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st       <= sps_pkg::SPS_ST_STATIC;
			idx      <= '0;
			loop_cnt <= '0;
			executed <= '0;
			pending  <= 1'b0;
		end else begin
			st       <= next_st;
			idx      <= next_idx;
			loop_cnt <= next_loop_cnt;
			executed <= next_executed;
			pending  <= next_pending;
		end
	end

	// Settings registers; changed only while static so the list stays stable.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			play_mode  <= sps_pkg::PLAY_RESET;
			trig_mode  <= sps_pkg::TRIG_RESET;
			loops      <= sps_pkg::LOOPS_RESET;
			num_states <= '0;
		end else if (reg_wr && st == sps_pkg::SPS_ST_STATIC) begin
			if (reg_addr == sps_pkg::REG_CONFIG) begin
				play_mode <= reg_wdata[sps_pkg::CFG_PLAY_LSB +: 2];
				trig_mode <= reg_wdata[sps_pkg::CFG_TRIG_LSB +: 2];
			end
			if (reg_addr == sps_pkg::REG_LOOPS) begin
				loops <= reg_wdata[15:0];
			end
			if (reg_addr == sps_pkg::REG_NUM_STATE) begin
				num_states <= reg_wdata[STATE_W:0];
			end
		end
	end

	// Duration table, one word per state from the table base.
	always_ff @(posedge mclk) begin
		if (reg_wr && st == sps_pkg::SPS_ST_STATIC && reg_addr >= sps_pkg::REG_TABLE
			&& reg_addr < sps_pkg::REG_TABLE + 8'(DEPTH * 4)) begin
			dur_mem[STATE_W'((reg_addr - sps_pkg::REG_TABLE) >> 2)] <= reg_wdata[DUR_W-1:0];
		end
	end

	// Read data, one cycle after the strobe; unmapped reads return zero.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				sps_pkg::REG_CONFIG:    rdata_q <= {28'h000_0000, trig_mode, play_mode};
				sps_pkg::REG_LOOPS:     rdata_q <= {16'h0000, loops};
				sps_pkg::REG_NUM_STATE: rdata_q <= 32'(num_states);
				sps_pkg::REG_STATUS:    rdata_q <= {27'h000_0000, pending, 1'b0, st};
				sps_pkg::REG_PROGRESS:  rdata_q <= {16'(num_states), 16'(executed)};
				sps_pkg::REG_LOOPCNT:   rdata_q <= {16'h0000, loop_cnt};
				default:                rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end
	assign reg_rdata = rdata_q;

	assign dyn_mode    = st != sps_pkg::SPS_ST_STATIC;
	assign state_apply = advance || (c_arm && st == sps_pkg::SPS_ST_STATIC && num_states != '0);
	assign state_index = idx;
	assign state_mon   = mon_busy && st != sps_pkg::SPS_ST_ARMED && dyn_mode;

endmodule
`default_nettype wire

// >>> dv/sps_trig_src.sv
// Trigger source model that drives the external trigger pin.
// Assumes the bench calls pulse from its main process.
`timescale 1ns/10ps
`default_nettype none
module sps_trig_src (
	input  wire logic mclk,
	output logic      trig_in
);
	// The pin idles low between trigger pulses.
	initial trig_in = 1'b0;
	// Each pulse stays high for four cycles so the input synchroniser sees it.
	task automatic pulse();
		@(posedge mclk);
		trig_in <= 1'b1;
		repeat (4) @(posedge mclk);
		trig_in <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> dv/sps_sequencer_asserts.sv
// Checker that watches the sequencer ports.
// Assumes it is bound onto every sps_sequencer instance.
`timescale 1ns/10ps
`default_nettype none
module sps_sequencer_chk #(
	parameter int unsigned STATE_W       = 4,
	parameter int unsigned MON_PULSE_CYC = 10
) (
	input wire logic               mclk,
	input wire logic               sys_rst,
	input wire logic [7:0]         reg_addr,
	input wire logic [31:0]        reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [31:0]        reg_rdata,
	input wire logic               state_mon,
	input wire logic               dyn_mode,
	input wire logic               state_apply,
	input wire logic [STATE_W-1:0] state_index
);
	// Cycles the monitor output has been high so far.
	logic [15:0] mon_len;
	logic [15:0] next_mon_len;
	// Counts while the pulse is high and clears when it drops.
	always_comb begin
		next_mon_len = state_mon ? mon_len + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge mclk) begin
		mon_len <= sys_rst ? 16'h0000 : next_mon_len;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data not zero outside answer");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == '0)
		else $error("unmapped read not zero");
	a_arm_first: assert property ($rose(dyn_mode) |-> $past(reg_wr) && state_index == '0)
		else $error("arm did not load first state");
	a_mon_armed_low: assert property ($rose(dyn_mode) |-> !state_mon ##1 !state_mon)
		else $error("monitor high while armed");
	// A stop may cut a pulse short; the output level after stop is left open.
	a_mon_width: assert property ($fell(state_mon) && dyn_mode |-> mon_len == 16'(MON_PULSE_CYC))
		else $error("monitor pulse width wrong");
	a_mon_cause: assert property ($rose(state_mon) |->
		$past(state_apply) || $past(state_apply, 2) || $past(state_apply, 3))
		else $error("monitor pulse without state change");
	a_stop_static: assert property (reg_wr && reg_addr == sps_pkg::REG_COMMAND
		&& reg_wdata[sps_pkg::CMD_STOP] |=> !dyn_mode)
		else $error("stop did not return to static");
	a_index_hold: assert property (dyn_mode && !state_apply |=>
		$stable(state_index) || !dyn_mode)
		else $error("state index moved without a change");
endmodule
bind sps_sequencer sps_sequencer_chk #(.STATE_W(STATE_W), .MON_PULSE_CYC(MON_PULSE_CYC)) u_chk (
	.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.state_mon, .dyn_mode, .state_apply, .state_index);
`default_nettype wire

// >>> dv/test_state_playback_sequencer.sv
// Testbench for the playback sequencer with a trigger source model.
// Assumes shortened trigger and monitor timing parameters.
`timescale 1ns/10ps
`default_nettype none
module test_state_playback_sequencer;
	logic        mclk, sys_rst, reg_wr, reg_rd, trig_in;
	logic        state_mon, dyn_mode, state_apply;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [3:0]  state_index, i0;
	int          err_count, tests_run, n;
	always #2.5 mclk = ~mclk;
	sps_trig_src src (.mclk(mclk), .trig_in(trig_in));
	sps_sequencer #(.EXT_DELAY_CYC(40), .EXT_REARM_CYC(30), .MON_PULSE_CYC(4)) dut (
		.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
		.state_mon(state_mon), .dyn_mode(dyn_mode), .state_apply(state_apply),
		.state_index(state_index));
	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic cmd(input int b);
		wr(sps_pkg::REG_COMMAND, 32'h0000_0001 << b);
	endtask
	// Waits for static mode (k 0) or an index change, counting cycles in n.
	task automatic wt(input int k, input int mx);
		#1 i0 = state_index;
		for (n = 1; n <= mx; n++) begin
			@(posedge mclk);
			#1;
			if (k == 0 ? !dyn_mode : state_index !== i0) return;
		end
		chk(0, 1, "wait bound");
		finish_test();
	endtask
	task automatic start(input logic [31:0] cfg);
		wr(sps_pkg::REG_CONFIG, cfg);
		cmd(sps_pkg::CMD_ARM);
		#1 chk(dyn_mode, 1, "armed");
		chk(state_index, 0, "first state");
		cmd(sps_pkg::CMD_RUN);
	endtask
	task automatic t_reset();
		rd(sps_pkg::REG_LOOPS);
		chk(d, 1, "loops reset");
		rd(8'h20);
		chk(d, 0, "unmapped");
		wr(sps_pkg::REG_NUM_STATE, 3);
		for (int i = 0; i < 3; i++) wr(8'h40 + 8'(4 * i), 8);
	endtask
	task automatic t_once();
		start(0);
		wt(0, 60);
		chk(n >= 23 && n <= 30, 1, "once length");
		rd(sps_pkg::REG_STATUS);
		chk(d[2:0], 0, "static again");
	endtask
	task automatic t_pause();
		start(0);
		repeat (4) @(posedge mclk);
		cmd(sps_pkg::CMD_PAUSE);
		#1 i0 = state_index;
		repeat (30) @(posedge mclk);
		#1 chk(state_index, i0, "frozen");
		rd(sps_pkg::REG_STATUS);
		chk(d[2:0], 3, "paused");
		cmd(sps_pkg::CMD_RESUME);
		wt(0, 40);
		chk(n >= 15 && n <= 22, 1, "resume rest");
	endtask
	task automatic t_loop();
		wr(sps_pkg::REG_LOOPS, 2);
		start(1);
		wt(0, 120);
		chk(n >= 47 && n <= 56, 1, "two passes");
		start(2);
		repeat (100) @(posedge mclk);
		#1 chk(dyn_mode, 1, "endless");
		cmd(sps_pkg::CMD_STOP);
		#1 chk(dyn_mode, 0, "stopped");
	endtask
	task automatic t_step();
		start(32'h0000_0004);
		repeat (20) @(posedge mclk);
		#1 chk(state_index, 0, "no timer");
		cmd(sps_pkg::CMD_STEP);
		#1;
		chk(state_index, 1, "one step");
		rd(sps_pkg::REG_PROGRESS);
		chk(d[31:16], 3, "total");
		chk(d[15:0], 1, "executed");
		cmd(sps_pkg::CMD_PAUSE);
		cmd(sps_pkg::CMD_STEP);
		repeat (5) @(posedge mclk);
		#1 chk(state_index, 1, "step paused");
		cmd(sps_pkg::CMD_STOP);
	endtask
	task automatic t_ext();
		start(32'h0000_000A);
		src.pulse();
		wt(1, 80);
		chk(n + 4 >= 40 && n + 4 <= 59, 1, "ext delay");
		src.pulse();
		repeat (3) @(posedge mclk);
		src.pulse();
		wt(1, 80);
		repeat (100) @(posedge mclk);
		#1 chk(state_index, i0 + 4'h1, "dropped");
		src.pulse();
		repeat (32) @(posedge mclk);
		src.pulse();
		wt(1, 80);
		wt(1, 80);
		chk(n >= 30, 1, "pending");
		cmd(sps_pkg::CMD_STOP);
	endtask
	initial begin
		mclk = 1'b0;
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		err_count = 0;
		tests_run = 0;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset();
		t_once();
		t_pause();
		t_loop();
		t_step();
		t_ext();
		finish_test();
	end
endmodule
`default_nettype wire
